// File: core/qfc_ctrl.sv
// Behaviour
// R1 - Heavy load: valley switching, period never below the maximum-frequency period.
// R2 - Medium load: period follows feedback, peak reference held near constant.
// R3 - Light load: minimum frequency, peak falls from half maximum to minimum.
// R4 - Burst: stop below enter level, resume above exit level, switch off between.
// R5 - Dither period and peak on a triangle stepped over 32 switching cycles.
// R6 - Peak comparator ignored during turn-on blanking after switch turn-on.
// R7 - Switch turns off when sensed peak exceeds feedback-derived limit.
// R8 - Turn on only at valley once period passes the frequency-limit interval.
// R9 - Without valley, force turn-on at the maximum switching period.
// R10 - Watch line input for AC removal, then discharge line capacitors.
// R11 - Aux sampling blanking grows with feedback before the sample is taken.
// R12 - Sense over-voltage: open-sense fault, stop, reset supply, restart.
// R13 - Line good: pull supply to undervoltage level, start at startup level.
// R14 - Line low for the whole line-loss delay disables the controller.
// R15 - Aux over-voltage on three consecutive samples: stop, reset supply, restart.
// R16 - First 100us of soft start: inject select current, choose power or current limit.
// R17 - Current limit: hold peak at turn-off, fault if estimate stays high for delay.
// R18 - After limit or overload faults: off for four undervoltage hits, restart fifth.
// R19 - Power limit: fault if power estimate stays above level for delay.
// R20 - Feedback above overload level beyond overload delay: fault and stop.
// R21 - Supply over-voltage held beyond 100us: fault, stop, reset supply, restart.
// R22 - Over-temperature stops; on cooling, supply reset and restart.
// R23 - Each start and restart runs a 4ms soft start from minimum to maximum.
// R24 - Analogue comparator results are synchronised before use.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module qfc_ctrl
	import qfc_pkg::*;
#(
	parameter logic [15:0]        MINP_CYC   = 16'(`QFC_KHZ_UP(`QFC_FMAX_KHZ)),
	parameter logic [15:0]        FMIN_CYC   = 16'(`QFC_KHZ_DN(`QFC_FMIN_KHZ)),
	parameter logic [15:0]        TSMAX_CYC  = 16'(`QFC_US(`QFC_TSMAX_US)),
	parameter logic [15:0]        TONMAX_CYC = 16'(`QFC_US(`QFC_TONMAX_US)),
	parameter logic [15:0]        LEB_CYC    = 16'(`QFC_NS_UP(`QFC_LEB_NS)),
	parameter logic [15:0]        TONMIN_CYC = 16'(`QFC_NS_UP(`QFC_TONMIN_NS)),
	parameter logic [15:0]        VSBMIN_CYC = 16'(`QFC_NS_UP(`QFC_VSBMIN_NS)),
	parameter logic [15:0]        VSBMAX_CYC = 16'(`QFC_NS_UP(`QFC_VSBMAX_NS)),
	parameter logic [11:0]        SS_STEP    = 12'(`QFC_US(`QFC_SS_US) / `QFC_SS_LEVELS),
	parameter logic [`QFC_TW-1:0] SEL_CYC    = `QFC_TW'(`QFC_US(`QFC_SEL_US)),
	parameter logic [`QFC_TW-1:0] VOV_CYC    = `QFC_TW'(`QFC_US(`QFC_VOV_US)),
	parameter logic [`QFC_TW-1:0] FLT_CYC    = `QFC_TW'(`QFC_US(`QFC_FLT_US)),
	parameter logic [`QFC_TW-1:0] BO_CYC     = `QFC_TW'(`QFC_US(`QFC_BO_US)),
	parameter logic [`QFC_TW-1:0] XCHK_CYC   = `QFC_TW'(`QFC_US(`QFC_XCHK_US)),
	parameter logic [`QFC_TW-1:0] XDIS_CYC   = `QFC_TW'(`QFC_US(`QFC_XDIS_US))
) (
	input  wire logic           i_ref_clk,
	input  wire logic           i_rst,
	input  wire logic           i_clk_en,
	input  wire qfc_cmp_type    i_cmp,
	input  wire logic [7:0]     i_fb_code,
	input  wire logic           i_hsel,
	input  wire logic [31:0]    i_haddr,
	input  wire logic [1:0]     i_htrans,
	input  wire logic           i_hwrite,
	input  wire logic [2:0]     i_hsize,
	input  wire logic [31:0]    i_hwdata,
	input  wire logic           i_hready,
	output logic                o_hreadyout,
	output logic                o_hresp,
	output logic [31:0]         o_hrdata,
	output qfc_drive_type       o_drive,
	output logic [7:0]          o_peak_ref,
	output logic [7:0]          o_ss_level,
	output qfc_region_type      o_region
);
	localparam qfc_state_type RST_VAL = '{prot: P_LINE, sw: S_IDLE, region: R_PWM,
		ena: `QFC_ENA_RST, dith: `QFC_DITH_RST, hready: 1'b1, default: '0};

	qfc_state_type  q;
	qfc_state_type  d;
	qfc_cmp_type    c;
	qfc_region_type rg;
	logic [7:0]     fb;
	logic [7:0]     pk;
	logic [7:0]     clr;
	logic [7:0]     fset;
	logic [11:0]    pm;
	logic [8:0]     ps;
	logic [3:0]     tri_s;
	logic [15:0]    per_lim;
	logic [15:0]    lim_j;
	logic [15:0]    blk_lim;
	logic [31:0]    rd;
	logic           a_ph;
	logic           go_ss;
	logic           go_hic;
	logic           go_rst;
	logic           lim_hit;

	function automatic qfc_region_type region_of(input logic [7:0] f, input logic b);
		if (b) begin
			return R_BURST;
		end
		if (f >= `QFC_FB_PFM) begin
			return R_QR;
		end
		if (f >= `QFC_FB_PWM) begin
			return R_PFM;
		end
		return R_PWM;
	endfunction

	qfc_sync u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_clk_en  (i_clk_en),
		.i_async   (i_cmp),
		.o_sync    (c)
	); // R24

	////////////////////////////////////////////////////////////////////////////////
	// Operating point from feedback

	always_comb begin
		// Soft start clamps the feedback seen by every region decision
		fb = (q.ss_level < i_fb_code) ? q.ss_level : i_fb_code; // R23
		rg = region_of(fb, q.burst);
		tri_s = q.jit_cnt[4] ? ~q.jit_cnt[3:0] : q.jit_cnt[3:0]; // R5
		case (rg)
			R_QR: begin
				per_lim = MINP_CYC; // R1
				pk = fb;
			end
			R_PFM: begin
				per_lim = FMIN_CYC - 16'((fb - `QFC_FB_PWM) * `QFC_PFM_STEP); // R2
				pk = `QFC_PEAK_HALF; // R2
			end
			default: begin
				per_lim = FMIN_CYC; // R3
				pk = (fb < `QFC_FB_BURL) ? `QFC_PEAK_MIN :
					8'((fb - `QFC_FB_BURL) * `QFC_PWM_GAIN) + `QFC_PEAK_MIN; // R3
			end
		endcase
		pm = 12'(pk * tri_s);
		ps = 9'(pk) - 9'(pk >> 4) + {4'h0, pm[11:7]};
		lim_j = per_lim - (per_lim >> 5) + 16'((per_lim >> 8) * tri_s); // R5
		if (!q.dith) begin
			lim_j = per_lim;
			ps = {1'b0, pk};
		end
		if (lim_j < MINP_CYC) begin
			lim_j = MINP_CYC; // R1
		end
		blk_lim = VSBMIN_CYC + 16'((16'(fb) * (VSBMAX_CYC - VSBMIN_CYC)) >> 8); // R11
		case (i_haddr[3:0])
			`QFC_REG_CTRL:   rd = {30'h0, q.dith, q.ena};
			`QFC_REG_STATUS: rd = {q.ss_level, q.peak_ref, q.region, 1'b0, q.sw, q.prot};
			`QFC_REG_FAULT:  rd = {24'h0, q.faults};
			default:         rd = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		fset = 8'h00;
		clr = 8'h00;
		go_ss = 1'b0;
		go_hic = 1'b0;
		go_rst = 1'b0;
		d.drv.peak_hold = 1'b0;
		d.drv.aux_sample = 1'b0;
		d.region = rg;
		d.peak_ref = ps[8] ? 8'hFF : ps[7:0];

		// Bus slave, zero wait states
		a_ph = i_hsel && i_htrans[1] && i_hready;
		d.wr_pend = a_ph && i_hwrite && (i_hsize == 3'h2);
		d.wr_addr = i_haddr[3:0];
		if (a_ph && !i_hwrite) begin
			d.hrdata = rd;
		end
		if (q.wr_pend) begin
			case (q.wr_addr)
				`QFC_REG_CTRL: begin
					d.ena = i_hwdata[0];
					d.dith = i_hwdata[1];
				end
				`QFC_REG_FAULT: clr = i_hwdata[7:0];
				default: ;
			endcase
		end

		// AC removal: no rectified-line edges for a whole check window
		d.line_prev = c.line_good;
		if (!q.drv.line_discharge) begin
			d.x_tmr = (c.line_good != q.line_prev) ? '0 : q.x_tmr + 1'b1; // R10
			if (q.x_tmr >= XCHK_CYC) begin
				d.drv.line_discharge = 1'b1; // R10
				d.x_tmr = '0;
			end
		end else begin
			// Only a rising edge means AC is back; decay gives falling ones
			d.x_tmr = q.x_tmr + 1'b1;
			if ((c.line_good && !q.line_prev) || q.x_tmr >= XDIS_CYC) begin
				d.drv.line_discharge = 1'b0;
				d.x_tmr = '0;
			end
		end

		// Burst hysteresis
		if (fb < `QFC_FB_BURL) begin
			d.burst = 1'b1; // R4
		end else if (fb > `QFC_FB_BURH) begin
			d.burst = 1'b0; // R4
		end

		// Soft-start ramp and brown-out timing while active
		if (q.prot == P_SELECT || q.prot == P_RUN) begin
			d.ss_div = q.ss_div + 1'b1;
			if (q.ss_div >= SS_STEP - 1'b1) begin
				d.ss_div = '0;
				if (q.ss_level != 8'hFF) begin
					d.ss_level = q.ss_level + 1'b1; // R23
				end
			end
			d.bo_tmr = c.line_loss ? q.bo_tmr + 1'b1 : '0; // R14
		end else begin
			d.bo_tmr = '0;
		end

		// Fault timers only run while switching
		lim_hit = q.use_power ? c.pow_over : c.cur_over; // R17 R19
		if (q.prot == P_RUN) begin
			d.lim_tmr = lim_hit ? q.lim_tmr + 1'b1 : '0;
			d.olp_tmr = (i_fb_code > `QFC_FB_OLP) ? q.olp_tmr + 1'b1 : '0; // R20
			d.vov_tmr = c.supply_ovp ? q.vov_tmr + 1'b1 : '0; // R21
		end else begin
			d.lim_tmr = '0;
			d.olp_tmr = '0;
			d.vov_tmr = '0;
		end

		case (q.prot)
			P_LINE: begin
				if (c.line_good && q.ena) begin
					d.prot = P_PULL; // R13
				end
			end
			P_PULL: begin
				if (c.supply_uv) begin
					d.prot = P_CHARGE; // R13
				end
			end
			P_CHARGE: begin
				if (c.supply_on) begin
					go_ss = 1'b1; // R13
				end
			end
			P_SELECT: begin
				d.tmr = q.tmr + 1'b1;
				if (q.tmr >= SEL_CYC - 1'b1) begin
					d.use_power = c.cs_sel; // R16
					d.prot = P_RUN;
					d.sw = S_WAIT;
					d.per_cnt = '0;
				end
			end
			P_RUN: begin
				if (c.temp_hot) begin
					d.prot = P_OTP; // R22
					fset[`QFC_F_OTP] = 1'b1;
				end else if (c.cs_ovp) begin
					go_rst = 1'b1; // R12
					fset[`QFC_F_CSOPEN] = 1'b1;
				end else if (q.vov_tmr >= VOV_CYC) begin
					go_rst = 1'b1; // R21
					fset[`QFC_F_VDDOVP] = 1'b1;
				end else if (q.lim_tmr >= FLT_CYC) begin
					go_hic = 1'b1; // R17 R19
					fset[q.use_power ? `QFC_F_POW : `QFC_F_CUR] = 1'b1;
				end else if (q.olp_tmr >= FLT_CYC) begin
					go_hic = 1'b1; // R20
					fset[`QFC_F_OLP] = 1'b1;
				end else if (c.supply_uv || !q.ena) begin
					d.prot = P_CHARGE;
				end
			end
			P_HICCUP: begin
				if (!q.chg && c.supply_uv) begin
					d.chg = 1'b1; // R18
					d.hic_cnt = q.hic_cnt + 1'b1;
				end else if (q.chg && c.supply_on) begin
					d.chg = 1'b0;
					if (q.hic_cnt == `QFC_HIC_N) begin
						go_ss = 1'b1; // R18
					end
				end
			end
			P_RESET: begin
				if (c.supply_rst) begin
					d.prot = P_CHARGE; // R12 R15 R21
				end
			end
			P_OTP: begin
				if (c.temp_cool) begin
					go_rst = 1'b1; // R22
				end
			end
			default: d.prot = P_LINE;
		endcase

		// Switching, only while running
		if (q.prot != P_RUN) begin
			d.drv.gate = 1'b0;
			if (q.prot != P_SELECT) begin
				d.sw = S_IDLE;
			end
		end else begin
			case (q.sw)
				S_ON: begin
					d.per_cnt = q.per_cnt + 1'b1;
					if ((q.on_cnt >= LEB_CYC && q.on_cnt >= TONMIN_CYC && c.cs_peak) ||
						q.on_cnt >= TONMAX_CYC) begin
						d.drv.gate = 1'b0; // R6 R7
						d.sw = S_WAIT;
						d.drv.peak_hold = 1'b1; // R17
						d.blanking = 1'b1;
						d.blk_cnt = '0;
					end else begin
						d.on_cnt = q.on_cnt + 1'b1;
					end
				end
				S_WAIT: begin
					if (q.per_cnt != 16'hFFFF) begin
						d.per_cnt = q.per_cnt + 1'b1;
					end
					if (q.blanking) begin
						d.blk_cnt = q.blk_cnt + 1'b1;
						if (q.blk_cnt >= blk_lim) begin
							d.blanking = 1'b0; // R11
							d.drv.aux_sample = 1'b1;
							d.ovp_cnt = c.aux_ovp ? q.ovp_cnt + 1'b1 : 2'h0; // R15
							if (c.aux_ovp && q.ovp_cnt == `QFC_AUX_OVP_N - 1'b1) begin
								go_rst = 1'b1; // R15
								fset[`QFC_F_AUXOVP] = 1'b1;
							end
						end
					end
					if (!q.burst && ((q.per_cnt >= lim_j && c.valley_detect && !q.blanking) ||
						q.per_cnt >= TSMAX_CYC)) begin
						d.drv.gate = 1'b1; // R4 R8 R9
						d.sw = S_ON;
						d.on_cnt = '0;
						d.per_cnt = '0;
						d.jit_cnt = q.jit_cnt + 1'b1; // R5
					end
				end
				default: d.sw = S_WAIT;
			endcase
		end

		if (d.bo_tmr >= BO_CYC) begin
			d.prot = P_LINE; // R14
			fset[`QFC_F_BROWN] = 1'b1;
		end else if (go_rst) begin
			d.prot = P_RESET; // R12
		end else if (go_hic) begin
			d.prot = P_HICCUP; // R18
			d.hic_cnt = '0;
			d.chg = 1'b0;
		end else if (go_ss) begin
			d.prot = P_SELECT; // R23
			d.tmr = '0;
			d.ss_level = '0;
			d.ss_div = '0;
		end
		if (d.prot != P_RUN) begin
			d.drv.gate = 1'b0;
			d.ovp_cnt = 2'h0;
		end
		d.drv.supply_pulldown = (d.prot == P_PULL); // R13
		d.drv.startup = (d.prot == P_CHARGE) || (d.prot == P_HICCUP && d.chg);
		d.drv.sel_current = (d.prot == P_SELECT); // R16
		d.drv.supply_reset = (d.prot == P_RESET);
		// Set wins over a clear in the same cycle
		d.faults = (q.faults & ~clr) | fset;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= RST_VAL;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	assign o_hreadyout = q.hready;
	assign o_hresp = 1'b0 & q.hready;
	assign o_hrdata = q.hrdata;
	assign o_drive = q.drv;
	assign o_peak_ref = q.peak_ref;
	assign o_ss_level = q.ss_level;
	assign o_region = q.region;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst || !i_clk_en);

	AST_FMAX: assert property ($rose(o_drive.gate) |-> $past(q.per_cnt) >= MINP_CYC) // R1
		else $error("turn-on before maximum-frequency period");
	AST_BURST_HOLD: assert property (q.burst |=> !$rose(o_drive.gate)) // R4
		else $error("turn-on while in burst pause");
	AST_LEB_HOLD: assert property (($fell(o_drive.gate) && q.prot == P_RUN) |-> // R6
		q.on_cnt >= LEB_CYC)
		else $error("pulse ended inside turn-on blanking");
	AST_PEAK_OFF: assert property ((q.prot == P_RUN && d.prot == P_RUN && q.sw == S_ON &&
		q.on_cnt >= LEB_CYC && q.on_cnt >= TONMIN_CYC && c.cs_peak) |=> !o_drive.gate) // R7
		else $error("switch stayed on past peak limit");
	AST_VALLEY_ON: assert property ($rose(o_drive.gate) |-> ($past(c.valley_detect) &&
		$past(q.per_cnt) >= $past(lim_j)) || $past(q.per_cnt) >= TSMAX_CYC) // R8
		else $error("turn-on without valley or timeout");
	AST_TSMAX_ON: assert property ((q.sw == S_WAIT && q.per_cnt >= TSMAX_CYC && !q.burst &&
		q.prot == P_RUN && d.prot == P_RUN) |=> o_drive.gate) // R9
		else $error("no forced turn-on at maximum period");
	AST_AUX_OVP: assert property ((q.prot == P_RUN && d.drv.aux_sample && c.aux_ovp &&
		q.ovp_cnt == `QFC_AUX_OVP_N - 1'b1) |=> q.faults[`QFC_F_AUXOVP]) // R15
		else $error("third aux over-voltage not flagged");
	AST_SEL_RESULT: assert property (($fell(o_drive.sel_current) && q.prot == P_RUN) |->
		q.use_power == $past(c.cs_sel)) // R16
		else $error("limit selection not taken from select sample");
	AST_HIC_FIVE: assert property (($past(q.prot) == P_HICCUP && q.prot == P_SELECT) |->
		$past(q.hic_cnt) == `QFC_HIC_N) // R18
		else $error("restart before fifth supply cycle");
	AST_VDD_OVP: assert property ((q.prot == P_RUN && q.vov_tmr >= VOV_CYC && !c.temp_hot &&
		!c.cs_ovp) |=> q.faults[`QFC_F_VDDOVP] ##1 q.prot != P_RUN) // R21
		else $error("supply over-voltage not acted on");
	AST_PULLDOWN: assert property ($rose(o_drive.supply_pulldown) |->
		$past(q.prot) == P_LINE && $past(c.line_good)) // R13
		else $error("supply pull-down without line good");

	COV_SWITCH: cover property ($rose(o_drive.gate));
	COV_HICCUP: cover property (q.prot == P_HICCUP ##1 q.prot == P_SELECT);
	COV_BURST: cover property (region_of(fb, q.burst) == R_BURST);
	COV_DISCH: cover property ($rose(o_drive.line_discharge));
endmodule
`default_nettype wire

// File: core/qfc_map.svh
`ifndef QFC_MAP_SVH
`define QFC_MAP_SVH

`define QFC_CLK_MHZ    250
`define QFC_LEB_NS     220
`define QFC_TONMIN_NS  325
`define QFC_TONMAX_US  18
`define QFC_TSMAX_US   61
`define QFC_FMAX_KHZ   210
`define QFC_FMIN_KHZ   25
`define QFC_VSBMIN_NS  600
`define QFC_VSBMAX_NS  1200
`define QFC_SEL_US     100
`define QFC_VOV_US     100
`define QFC_SS_US      4000
`define QFC_FLT_US     106500
`define QFC_BO_US      62000
`define QFC_XCHK_US    16000
`define QFC_XDIS_US    2000000

`define QFC_NS_UP(t)   (((t) * `QFC_CLK_MHZ + 999) / 1000)
`define QFC_NS_DN(t)   (((t) * `QFC_CLK_MHZ) / 1000)
`define QFC_US(t)      ((t) * `QFC_CLK_MHZ)
`define QFC_KHZ_UP(f)  ((`QFC_CLK_MHZ * 1000 + (f) - 1) / (f))
`define QFC_KHZ_DN(f)  ((`QFC_CLK_MHZ * 1000) / (f))

`define QFC_TW         30
`define QFC_SS_LEVELS  256

`define QFC_FB_PFM     8'hB3
`define QFC_FB_PWM     8'h40
`define QFC_FB_BURL    8'h20
`define QFC_FB_BURH    8'h26
`define QFC_FB_OLP     8'hEC
`define QFC_PEAK_HALF  8'h80
`define QFC_PEAK_MIN   8'h20
`define QFC_PWM_GAIN   8'h03
`define QFC_PFM_STEP   16'h004D

`define QFC_AUX_OVP_N  2'h3
`define QFC_HIC_N      3'h4

`define QFC_REG_CTRL   4'h0
`define QFC_REG_STATUS 4'h4
`define QFC_REG_FAULT  4'h8
`define QFC_ENA_RST    1'b1
`define QFC_DITH_RST   1'b1

`define QFC_F_CSOPEN   0
`define QFC_F_AUXOVP   1
`define QFC_F_VDDOVP   2
`define QFC_F_CUR      3
`define QFC_F_POW      4
`define QFC_F_OLP      5
`define QFC_F_OTP      6
`define QFC_F_BROWN    7

`endif

// File: core/qfc_pkg.sv
`include "qfc_map.svh"
package qfc_pkg;

	typedef enum logic [7:0] {
		P_LINE = 8'h01, P_PULL = 8'h02, P_CHARGE = 8'h04, P_SELECT = 8'h08,
		P_RUN = 8'h10, P_HICCUP = 8'h20, P_RESET = 8'h40, P_OTP = 8'h80
	} qfc_prot_type;

	typedef enum logic [2:0] {S_IDLE = 3'h1, S_ON = 3'h2, S_WAIT = 3'h4} qfc_sw_type;

	typedef enum logic [3:0] {
		R_QR = 4'h1, R_PFM = 4'h2, R_PWM = 4'h4, R_BURST = 4'h8
	} qfc_region_type;

	typedef struct packed {
		logic cs_peak;
		logic cs_ovp;
		logic cs_sel;
		logic valley_detect;
		logic line_good;
		logic line_loss;
		logic aux_ovp;
		logic supply_on;
		logic supply_uv;
		logic supply_rst;
		logic supply_ovp;
		logic temp_hot;
		logic temp_cool;
		logic cur_over;
		logic pow_over;
	} qfc_cmp_type;

	typedef struct packed {
		logic gate;
		logic peak_hold;
		logic aux_sample;
		logic sel_current;
		logic supply_pulldown;
		logic supply_reset;
		logic startup;
		logic line_discharge;
	} qfc_drive_type;

	typedef struct packed {
		qfc_cmp_type meta;
		qfc_cmp_type stable;
	} qfc_sync_state_type;

	typedef struct packed {
		qfc_prot_type             prot;
		qfc_sw_type               sw;
		qfc_region_type           region;
		qfc_drive_type            drv;
		logic [7:0]               peak_ref;
		logic [7:0]               ss_level;
		logic [11:0]              ss_div;
		logic [15:0]              on_cnt;
		logic [15:0]              per_cnt;
		logic [15:0]              blk_cnt;
		logic                     blanking;
		logic                     burst;
		logic [1:0]               ovp_cnt;
		logic [2:0]               hic_cnt;
		logic                     chg;
		logic [4:0]               jit_cnt;
		logic [`QFC_TW-1:0]       tmr;
		logic [`QFC_TW-1:0]       lim_tmr;
		logic [`QFC_TW-1:0]       olp_tmr;
		logic [`QFC_TW-1:0]       bo_tmr;
		logic [`QFC_TW-1:0]       vov_tmr;
		logic [`QFC_TW-1:0]       x_tmr;
		logic                     line_prev;
		logic                     use_power;
		logic                     ena;
		logic                     dith;
		logic [7:0]               faults;
		logic [31:0]              hrdata;
		logic                     hready;
		logic                     wr_pend;
		logic [3:0]               wr_addr;
	} qfc_state_type;

endpackage

// File: core/qfc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module qfc_sync
	import qfc_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        i_clk_en,
	input  wire qfc_cmp_type i_async,
	output var  qfc_cmp_type o_sync
);
	qfc_sync_state_type q;
	qfc_sync_state_type d;

	always_comb begin
		d.meta   = i_async;
		d.stable = q.meta;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			q <= '0;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	assign o_sync = q.stable;
endmodule
`default_nettype wire

// File: tb/qfc_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
module qfc_stage_model (
	input  wire logic i_ref_clk,
	input  wire logic i_ring,
	input  wire logic i_gate,
	output logic      o_cs_peak,
	output logic      o_valley
);
	// Known start so the first valley pulses are clean
	logic [9:0] cnt_q  = 10'h000;
	logic       gate_q = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_ref_clk) begin
		gate_q <= i_gate;
		cnt_q  <= (gate_q != i_gate) ? 10'h000 : cnt_q + 10'h001;
	end

	// Steep current ramp: trips inside the blanking window on purpose
	assign o_cs_peak = i_gate && cnt_q >= 10'h00A;
	// Ringing after demagnetisation gives short dips every 32 cycles
	assign o_valley = i_ring && !i_gate && cnt_q[4:0] == 5'h00;
endmodule
`default_nettype wire

// File: tb/qr_flyback_mode_fault_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module qr_flyback_mode_fault_control_tb_top;
	import qfc_pkg::*;
	logic           clk;
	logic           rst;
	logic           ce;
	logic           ring;
	logic           pk;
	logic           vl;
	logic [7:0]     fb;
	qfc_cmp_type    cmp;
	qfc_cmp_type    dcmp;
	logic           hsel;
	logic [31:0]    haddr;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [2:0]     hsize;
	logic [31:0]    hwdata;
	logic           hrdy;
	logic           hresp;
	logic [31:0]    hrdata;
	qfc_drive_type  drv;
	logic [7:0]     pref;
	logic [7:0]     ssl;
	qfc_region_type rg;
	logic [31:0]    rdv;
	int             n_errors;
	int             compares;
	int             cyc;

	always #2 clk = ~clk;
	always_comb begin
		dcmp = cmp;
		dcmp.cs_peak = pk;
		dcmp.valley_detect = vl;
	end

	qfc_stage_model i_stage (.i_ref_clk(clk), .i_ring(ring), .i_gate(drv.gate),
		.o_cs_peak(pk), .o_valley(vl));

	// Short counts keep the run small; forced period stays above the maximum-frequency one
	qfc_ctrl #(.TSMAX_CYC(16'h0578), .SS_STEP(12'h002), .SEL_CYC(30'h14),
		.FLT_CYC(30'h32), .BO_CYC(30'h32)) i_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_clk_en(ce), .i_cmp(dcmp), .i_fb_code(fb),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
		.o_hresp(hresp), .o_hrdata(hrdata), .o_drive(drv), .o_peak_ref(pref),
		.o_ss_level(ssl), .o_region(rg));

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic rng(input string n, input logic [15:0] lo, hi, v);
		compares++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			n_errors++;
			$display("mismatch %s exp %0d..%0d got %0d", n, lo, hi, v);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rdv = hrdata;
	endtask

	// Polls the state field over the bus, bounded
	task automatic wprot(input logic [7:0] p);
		int i;
		i = 0;
		do begin
			ahb(1'b0, 32'h4, 32'h0);
			i++;
		end while (rdv[7:0] !== p && i < 3000);
		chk("prot", {24'h0, p}, {24'h0, rdv[7:0]});
	endtask

	task automatic per(output int on, output int pr, output int ph);
		int n;
		n = 0;
		while (drv.gate !== 1'b0 && n < 2999) begin
			@(posedge clk);
			n++;
		end
		while (drv.gate !== 1'b1 && n < 2999) begin
			@(posedge clk);
			n++;
		end
		on = 0;
		while (drv.gate === 1'b1 && on < 2999) begin
			@(posedge clk);
			on++;
		end
		ph = int'(drv.peak_hold === 1'b1);
		pr = on;
		while (drv.gate !== 1'b1 && pr < 2999) begin
			@(posedge clk);
			pr++;
			if (drv.peak_hold === 1'b1)
				ph++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_start();
		chk("hresp", 32'h0, {31'h0, hresp});
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl", 32'h3, rdv);
		ahb(1'b0, 32'hC, 32'h0);
		chk("unmapped", 32'h0, rdv);
		// Byte-sized write must be ignored
		hsize <= 3'h0;
		ahb(1'b1, 32'h0, 32'h0);
		hsize <= 3'h2;
		ahb(1'b0, 32'h0, 32'h0);
		chk("byte write", 32'h3, rdv);
		ahb(1'b1, 32'h0, 32'h2);
		cmp.line_good <= 1'b1;
		repeat (10) @(posedge clk);
		wprot(8'h01);
		ahb(1'b1, 32'h0, 32'h3);
		wprot(8'h02);
		chk("pulldown", 32'h1, {31'h0, drv.supply_pulldown});
		cmp.supply_uv <= 1'b1;
		wprot(8'h04);
		chk("startup", 32'h1, {31'h0, drv.startup});
		cmp.supply_uv <= 1'b0;
		cmp.supply_on <= 1'b1;
		cmp.cs_sel <= 1'b1;
		wprot(8'h08);
		chk("sel", 32'h1, {31'h0, drv.sel_current});
		chk("sel gate", 32'h0, {31'h0, drv.gate});
		wprot(8'h10);
		chk("sel end", 32'h0, {31'h0, drv.sel_current});
		cmp.cs_sel <= 1'b0;
		rng("ss start", 16'h0, 16'hFE, {8'h0, ssl});
		repeat (600) @(posedge clk);
		chk("ss end", 32'hFF, {24'h0, ssl});
		$display("test start done");
	endtask

	task automatic t_switch();
		int on;
		int pr;
		int ph;
		ring <= 1'b1;
		per(on, pr, ph);
		per(on, pr, ph);
		rng("on", 16'd82, 16'd88, on[15:0]);
		rng("period", 16'd1191, 16'd1399, pr[15:0]);
		chk("hold", 32'h1, ph);
		chk("region", R_QR, rg);
		ring <= 1'b0;
		per(on, pr, ph);
		per(on, pr, ph);
		rng("forced", 16'd1400, 16'd1405, pr[15:0]);
		fb <= 8'h80;
		repeat (20) @(posedge clk);
		chk("region", R_PFM, rg);
		rng("peak", 16'h78, 16'h88, {8'h0, pref});
		fb <= 8'h30;
		repeat (20) @(posedge clk);
		chk("region", R_PWM, rg);
		rng("peak", 16'h4A, 16'h56, {8'h0, pref});
		fb <= 8'h10;
		repeat (100) @(posedge clk);
		chk("region", R_BURST, rg);
		on = 0;
		repeat (500) begin
			@(posedge clk);
			if (drv.gate !== 1'b0)
				on++;
		end
		chk("burst gate", 32'h0, on);
		fb <= 8'h24;
		repeat (20) @(posedge clk);
		chk("region", R_BURST, rg);
		fb <= 8'h30;
		per(on, pr, ph);
		rng("resume", 16'd1400, 16'd1405, pr[15:0]);
		$display("test switch done");
	endtask

	task automatic t_faults();
		int i;
		fb <= 8'hC0;
		ring <= 1'b1;
		cmp.aux_ovp <= 1'b1;
		wprot(8'h40);
		chk("supply reset", 32'h1, {31'h0, drv.supply_reset});
		cmp.aux_ovp <= 1'b0;
		ahb(1'b0, 32'h8, 32'h0);
		chk("fault", 32'h2, rdv);
		ahb(1'b1, 32'h8, 32'h2);
		ahb(1'b0, 32'h8, 32'h0);
		chk("fault clr", 32'h0, rdv);
		// Supply low first, else the charge state lasts one cycle only
		cmp.supply_on <= 1'b0;
		cmp.supply_rst <= 1'b1;
		wprot(8'h04);
		cmp.supply_rst <= 1'b0;
		cmp.supply_on <= 1'b1;
		wprot(8'h10);
		fb <= 8'hFF;
		wprot(8'h20);
		cmp.supply_on <= 1'b0;
		fb <= 8'hC0;
		// Four low-supply hits, then the restart
		for (i = 1; i <= 4; i++) begin
			cmp.supply_uv <= 1'b1;
			repeat (6) @(posedge clk);
			cmp.supply_uv <= 1'b0;
			cmp.supply_on <= 1'b1;
			repeat (6) @(posedge clk);
			if (i < 4) begin
				cmp.supply_on <= 1'b0;
				wprot(8'h20);
			end
		end
		wprot(8'h10);
		// Line gone too, so the disabled state is not left at once
		cmp.line_good <= 1'b0;
		cmp.line_loss <= 1'b1;
		wprot(8'h01);
		ahb(1'b0, 32'h8, 32'h0);
		chk("fault", 32'hA0, rdv);
		$display("test faults done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			final_report();
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		ring = 1'b0;
		fb = 8'hC0;
		cmp = '0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_errors = 0;
		compares = 0;
		cyc = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_start();
		t_switch();
		t_faults();
		final_report();
	end
endmodule
`default_nettype wire
